// ### hdl/sxirq_pkg.sv
// Package of constants for the shared interrupt and trap vectoring block.
// Assumes a single core clock domain and a plain register port.
package sxirq_pkg;
   // Register indices on the plain register port (byte address = 4 * index)
   localparam logic [3:0] ADDR_SEL0      = 4'h0;
   localparam logic [3:0] ADDR_SEL1      = 4'h1;
   localparam logic [3:0] ADDR_SEL2      = 4'h2;
   localparam logic [3:0] ADDR_SEL3      = 4'h3;
   localparam logic [3:0] ADDR_TRAPFLAG  = 4'h4;
   localparam logic [3:0] ADDR_TRAPSTAT  = 4'h5;
   // Select register layout
   localparam int SEL_EN_LSB   = 8;
   localparam int SEL_FLAG_MSB = 7;
   localparam logic [15:0] SEL_RESET = 16'h0000;
   // Trap flag register bit positions
   localparam int TF_NMI    = 15;
   localparam int TF_STACK_OVER_FLAG  = 14;
   localparam int TF_STACK_UNDER_FLAG  = 13;
   localparam int TF_BAD_OPCODE_FLAG = 7;
   localparam int TF_MULTIPLY_ACCUMULATE_TRAP_FLAG = 6;
   localparam int TF_PROTECTED_INSTR_FAULT_FLAG = 3;
   localparam int TF_OPA    = 2;
   localparam int TF_INA    = 1;
   localparam int TF_BUS    = 0;
   localparam logic [15:0] TF_RESET = 16'h0000;
   // Trap numbers; vector location is four times the number
   localparam logic [6:0] TN_RESET  = 7'h00;
   localparam logic [6:0] TN_NMI    = 7'h02;
   localparam logic [6:0] TN_STACK_OVER_FLAG  = 7'h04;
   localparam logic [6:0] TN_STACK_UNDER_FLAG  = 7'h06;
   localparam logic [6:0] TN_CLASSB = 7'h0A;
   // Priority levels: 3 reset, 2 class A, 1 class B
   localparam logic [1:0] PRIO_RESET  = 2'h3;
   localparam logic [1:0] PRIO_CLASSA = 2'h2;
   localparam logic [1:0] PRIO_CLASSB = 2'h1;
   localparam logic [3:0] ILVL_MAX    = 4'hF;
   // Source positions inside each select byte
   localparam int SRC_CAN   = 0;
   localparam int SRC_I2C_R = 1;
   localparam int SRC_I2C_T = 2;
   localparam int SRC_SS_R  = 3;
   localparam int SRC_SS_T  = 4;
   localparam int SRC_AS_R  = 5;
   localparam int SRC_AS_T  = 6;
   localparam int SRC_AS_TB = 7;
   // Vector 3 sources
   localparam int SRC3_FIRST_CAN_UNIT = 0;
   localparam int SRC3_SECOND_CAN_UNIT = 1;
   localparam int SRC3_I2CE = 2;
   localparam int SRC3_SSE  = 3;
   localparam int SRC3_ASE  = 4;
   localparam int SRC3_PLL  = 5;
   localparam int SRC3_PWM  = 6;
endpackage

// ### hdl/sxirq_vector.sv
// One shared vector: enable byte, sticky flag byte and the masked request.
// Assumes same-clock source pulses and the plain register port of the top.
`timescale 1ns/1ps
`default_nettype none
module sxirq_vector #(
   parameter int N_SRC = 8
) (
   // Clock and reset
   input  wire logic             i_core_clk,
   input  wire logic             i_reset_n,
   // Sources and register write
   input  wire logic [N_SRC-1:0] i_event,
   input  wire logic             i_wr,
   input  wire logic [15:0]      i_wdata,
   // State
   output logic      [15:0]      o_sel,
   output logic                  o_req
);
   logic [N_SRC-1:0] en_ff;
   logic [N_SRC-1:0] flag_ff;
   logic [N_SRC-1:0] nxt_en;
   logic [N_SRC-1:0] nxt_flag;

   // Event set wins over a same-cycle software clear
   assign nxt_en   = i_wr ? i_wdata[sxirq_pkg::SEL_EN_LSB +: N_SRC] : en_ff;
   assign nxt_flag = (i_wr ? i_wdata[N_SRC-1:0] : flag_ff) | i_event;

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         en_ff   <= sxirq_pkg::SEL_RESET[sxirq_pkg::SEL_EN_LSB +: N_SRC];
         flag_ff <= sxirq_pkg::SEL_RESET[N_SRC-1:0];
      end else begin
         en_ff   <= nxt_en;
         flag_ff <= nxt_flag;
      end
   end

   assign o_sel = {8'(en_ff), 8'(flag_ff)};
   assign o_req = |(en_ff & flag_ff);

   property p_flag_sticky;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      ($past(i_event) != '0) |-> ((flag_ff & $past(i_event)) == $past(i_event));
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("event flag not set");
endmodule // sxirq_vector
`default_nettype wire

// ### hdl/sxirq_top.sv
// Shared extension interrupt vectors plus reset and hardware trap classing.
// Assumes peripheral and CPU event pulses synchronous to i_core_clk.
// What this block does
// - Four 16-bit select registers hold enables in bits 15:8 and flags in bits 7:0.
// - A shared vector requests only for sources whose enable bit is set.
// - A source flag is set on its event even when the source is disabled.
// - I2C, second sync and async serial receive/transmit and async tx-buffer reach vectors 0-2.
// - Error events and PLL/watchdog go to vector 3; FIRST_CAN_UNIT to 0,3; SECOND_CAN_UNIT to 1,3; PWM to 2,3.
// - All resets form one class at vector 0 with trap number 0 and top priority.
// - Class A traps have own vectors 08h, 10h and 18h.
// - Class A traps sit below resets and above class B.
// - Six class B conditions share vector 28h with trap number 0Ah.
// - Class B traps share the lowest trap priority.
// - Servicing any reset or hardware trap forces the CPU interrupt level to 15; software traps leave it unchanged.
// - Each hardware trap sets its own bit in the trap flag register.
// - A hardware trap preempts only lower-priority trap service and blocks interrupts while serviced; software traps do neither.
`timescale 1ns/1ps
`default_nettype none
module sxirq_top (
   // Clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_reset_n,
   // Register port
   input  wire logic [3:0]  i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [15:0] o_rdata,
   // Peripheral events, one-cycle pulses
   input  wire logic        i_first_can_unit_evt,
   input  wire logic        i_second_can_unit_evt,
   input  wire logic        i_i2c_rx_evt,
   input  wire logic        i_i2c_tx_evt,
   input  wire logic        i_i2c_err_evt,
   input  wire logic        i_sync_rx_evt,
   input  wire logic        i_sync_tx_evt,
   input  wire logic        i_sync_err_evt,
   input  wire logic        i_async_rx_evt,
   input  wire logic        i_async_tx_evt,
   input  wire logic        i_async_txb_evt,
   input  wire logic        i_async_err_evt,
   input  wire logic        i_pll_owd_evt,
   input  wire logic        i_pwm_evt,
   // Reset and trap causes from the core, one-cycle pulses
   input  wire logic        i_soft_reset,
   input  wire logic        i_wdt_reset,
   input  wire logic        i_nmi,
   input  wire logic        i_stack_over,
   input  wire logic        i_stack_under,
   input  wire logic [5:0]  i_class_b,
   // Software trap instruction
   input  wire logic        i_sw_trap,
   input  wire logic [6:0]  i_sw_trap_num,
   // Trap service handshake
   input  wire logic        i_trap_done,
   // Shared vector requests
   output logic      [3:0]  o_shared_vector,
   // Exception taken
   output logic             o_trap_take,
   output logic      [6:0]  o_trap_num,
   output logic      [8:0]  o_vector_loc,
   output logic      [1:0]  o_trap_prio,
   output logic             o_force_ilvl,
   output logic      [3:0]  o_cpu_interrupt_level,
   output logic             o_irq_block
);
   ////////////////////////////////////////////////////////////////////////
   // Shared vectors
   logic [7:0]  src_v0;
   logic [7:0]  src_v1;
   logic [7:0]  src_v2;
   logic [7:0]  src_v3;
   logic [7:0]  src_mid;
   logic [15:0] sel_q [4];
   logic [3:0]  req_w;
   logic [3:0]  sel_wr;

   // Receive/transmit sources common to vectors 0..2
   assign src_mid = {i_async_txb_evt, i_async_tx_evt, i_async_rx_evt, i_sync_tx_evt,
                     i_sync_rx_evt, i_i2c_tx_evt, i_i2c_rx_evt, 1'b0};
   assign src_v0 = src_mid | {7'h00, i_first_can_unit_evt};
   assign src_v1 = src_mid | {7'h00, i_second_can_unit_evt};
   assign src_v2 = src_mid | {7'h00, i_pwm_evt};
   assign src_v3 = {1'b0, i_pwm_evt, i_pll_owd_evt, i_async_err_evt, i_sync_err_evt,
                    i_i2c_err_evt, i_second_can_unit_evt, i_first_can_unit_evt};

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_vec
         logic [7:0] src_g;
         assign src_g     = (g == 0) ? src_v0 : (g == 1) ? src_v1 :
                            (g == 2) ? src_v2 : src_v3;
         assign sel_wr[g] = i_wr && (i_addr == 4'(g));
         sxirq_vector #(.N_SRC(8)) u_vec (
            .i_core_clk (i_core_clk),
            .i_reset_n  (i_reset_n),
            .i_event    (src_g),
            .i_wr       (sel_wr[g]),
            .i_wdata    (i_wdata),
            .o_sel      (sel_q[g]),
            .o_req      (req_w[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Trap flag register
   logic [15:0] trap_flag_ff;
   logic [15:0] nxt_trap_flag;
   logic [15:0] trap_evt;
   logic        tf_wr;

   assign trap_evt = {i_nmi, i_stack_over, i_stack_under, 5'h00, i_class_b[5], i_class_b[4],
                      2'h0, i_class_b[3:0]};
   assign tf_wr    = i_wr && (i_addr == sxirq_pkg::ADDR_TRAPFLAG);
   // Software writes zero to clear; new trap events still win
   assign nxt_trap_flag = (tf_wr ? (trap_flag_ff & i_wdata) : trap_flag_ff) | trap_evt;

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) trap_flag_ff <= sxirq_pkg::TF_RESET;
      else            trap_flag_ff <= nxt_trap_flag;
   end

   ////////////////////////////////////////////////////////////////////////
   // Exception classing and priority
   typedef enum logic [2:0] {
      SXIRQ_IDLE  = 3'b001,
      SXIRQ_SERV  = 3'b010,
      SXIRQ_RSTEP = 3'b100
   } sxirq_state_t;

   sxirq_state_t state_ff;
   sxirq_state_t nxt_state;
   logic [1:0]   prio_ff;
   logic         rst_any;
   logic         a_any;
   logic         b_any;
   logic [1:0]   cand_prio;
   logic [6:0]   cand_num;
   logic         hw_take;
   logic         sw_take;
   logic         pend_a_ff;
   logic         pend_b_ff;
   logic [2:0]   pend_a_src_ff;
   logic         boot_ff;

   // Hardware reset enters as a pending reset-class exception
   assign rst_any = i_soft_reset | i_wdt_reset | boot_ff;
   assign a_any   = pend_a_ff | i_nmi | i_stack_over | i_stack_under;
   assign b_any   = pend_b_ff | (|i_class_b);

   // Fixed class order, NMI before stack faults inside class A
   assign cand_prio = rst_any ? sxirq_pkg::PRIO_RESET :
                      a_any   ? sxirq_pkg::PRIO_CLASSA :
                      b_any   ? sxirq_pkg::PRIO_CLASSB : 2'h0;
   assign cand_num  = rst_any ? sxirq_pkg::TN_RESET :
                      a_any   ? ((i_nmi | pend_a_src_ff[2])       ? sxirq_pkg::TN_NMI   :
                                 (i_stack_over | pend_a_src_ff[1]) ? sxirq_pkg::TN_STACK_OVER_FLAG :
                                                                     sxirq_pkg::TN_STACK_UNDER_FLAG)
                              : sxirq_pkg::TN_CLASSB;
   // Preempt only a lower-priority service
   assign hw_take   = (cand_prio != 2'h0) &&
                      ((state_ff == SXIRQ_IDLE) || (cand_prio > prio_ff));
   // Software traps only while no trap service runs
   assign sw_take   = i_sw_trap && !hw_take && (state_ff == SXIRQ_IDLE);

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         SXIRQ_IDLE:  if (hw_take) nxt_state = SXIRQ_SERV;
         SXIRQ_SERV:  if (hw_take) nxt_state = SXIRQ_RSTEP;
                      else if (i_trap_done) nxt_state = SXIRQ_IDLE;
         SXIRQ_RSTEP: if (hw_take) nxt_state = SXIRQ_RSTEP;
                      else nxt_state = SXIRQ_SERV;
         default:     nxt_state = SXIRQ_IDLE;
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_ff      <= SXIRQ_IDLE;
         prio_ff       <= 2'h0;
         boot_ff       <= 1'b1;
         pend_a_ff     <= 1'b0;
         pend_b_ff     <= 1'b0;
         pend_a_src_ff <= 3'h0;
      end else begin
         state_ff <= nxt_state;
         boot_ff  <= 1'b0;
         // Traps of a losing class wait until the running service is done; class A causes not taken with a class A take are dropped
         pend_a_ff     <= a_any && !(hw_take && cand_prio == sxirq_pkg::PRIO_CLASSA);
         pend_b_ff     <= b_any && !(hw_take && cand_prio == sxirq_pkg::PRIO_CLASSB);
         pend_a_src_ff <= (hw_take && cand_prio == sxirq_pkg::PRIO_CLASSA) ? 3'h0 :
                          pend_a_src_ff | {i_nmi, i_stack_over, i_stack_under};
         if (hw_take) prio_ff <= cand_prio;
         else if (state_ff == SXIRQ_SERV && i_trap_done) prio_ff <= 2'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registered outputs
   logic [3:0]  shv_ff;
   logic        take_ff;
   logic [6:0]  num_ff;
   logic [1:0]  oprio_ff;
   logic        force_ff;
   logic [3:0]  ilvl_ff;
   logic        blk_ff;
   logic [15:0] rdata_ff;
   logic [15:0] rd_mux;

   assign rd_mux = (i_addr < 4'h4)                   ? sel_q[i_addr[1:0]] :
                   (i_addr == sxirq_pkg::ADDR_TRAPFLAG) ? trap_flag_ff :
                   (i_addr == sxirq_pkg::ADDR_TRAPSTAT) ? {11'h000, prio_ff,
                                                          state_ff} : 16'h0000;

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         shv_ff   <= 4'h0;
         take_ff  <= 1'b0;
         num_ff   <= 7'h00;
         oprio_ff <= 2'h0;
         force_ff <= 1'b0;
         ilvl_ff  <= 4'h0;
         blk_ff   <= 1'b0;
         rdata_ff <= 16'h0000;
      end else begin
         shv_ff   <= req_w & {4{state_ff == SXIRQ_IDLE}};
         take_ff  <= hw_take | sw_take;
         num_ff   <= hw_take ? cand_num : sw_take ? i_sw_trap_num : num_ff;
         oprio_ff <= hw_take ? cand_prio : sw_take ? 2'h0 : oprio_ff;
         force_ff <= hw_take;
         ilvl_ff  <= hw_take ? sxirq_pkg::ILVL_MAX : ilvl_ff;
         blk_ff   <= (nxt_state != SXIRQ_IDLE);
         rdata_ff <= i_rd ? rd_mux : 16'h0000;
      end
   end

   assign o_shared_vector       = shv_ff;
   assign o_trap_take           = take_ff;
   assign o_trap_num            = num_ff;
   assign o_vector_loc          = {num_ff, 2'b00};
   assign o_trap_prio           = oprio_ff;
   assign o_force_ilvl          = force_ff;
   assign o_cpu_interrupt_level = ilvl_ff;
   assign o_irq_block           = blk_ff;
   assign o_rdata               = rdata_ff;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   property p_reset_first;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      (i_soft_reset | i_wdt_reset) |=> (o_trap_take && o_trap_num == 7'h00 && o_trap_prio == 2'h3);
   endproperty
   a_reset_first: assert property (p_reset_first) else $error("reset class not taken");

   property p_a_over_b;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      (state_ff == SXIRQ_IDLE && !rst_any && i_nmi && (|i_class_b))
      |=> (o_trap_num == 7'h02 && o_trap_prio == 2'h2);
   endproperty
   a_a_over_b: assert property (p_a_over_b) else $error("class A lost to class B");

   property p_classb_vec;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      (state_ff == SXIRQ_IDLE && !rst_any && !a_any && (|i_class_b))
      |=> (o_vector_loc == 9'h028 && o_trap_prio == 2'h1);
   endproperty
   a_classb_vec: assert property (p_classb_vec) else $error("class B vector wrong");

   property p_ilvl;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      hw_take |=> (o_cpu_interrupt_level == 4'hF && o_force_ilvl);
   endproperty
   a_ilvl: assert property (p_ilvl) else $error("level not forced");

   property p_block;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      (state_ff != SXIRQ_IDLE) |=> (o_shared_vector == 4'h0);
   endproperty
   a_block: assert property (p_block) else $error("interrupt during trap");

   property p_trapflag;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      i_stack_over |=> trap_flag_ff[sxirq_pkg::TF_STACK_OVER_FLAG];
   endproperty
   a_trapflag: assert property (p_trapflag) else $error("trap flag missing");

   property p_mask;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      (state_ff == SXIRQ_IDLE && sel_q[3][15:8] == 8'h00) |=> !o_shared_vector[3];
   endproperty
   a_mask: assert property (p_mask) else $error("masked vector raised");

   property p_first_can_unit_route;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      i_first_can_unit_evt |=> (sel_q[0][0] && sel_q[3][0]);
   endproperty
   a_first_can_unit_route: assert property (p_first_can_unit_route) else $error("FIRST_CAN_UNIT route wrong");
endmodule // sxirq_top
`default_nettype wire

// ### verification/sxirq_cpu_model.sv
// Behavioural core that services each taken exception and reports completion.
// Assumes o_trap_take is a one-cycle pulse on the core clock.
`timescale 1ns/1ps
`default_nettype none
module sxirq_cpu_model (
   // Clock and reset
   input  wire logic i_core_clk,
   input  wire logic i_reset_n,
   // Exception handshake
   input  wire logic i_trap_take,
   input  wire logic i_slow,
   output logic      o_trap_done
);
   logic     busy_ff;
   int       cnt_ff;

   // Slow mode keeps a service open long enough to poke at it
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         busy_ff     <= 1'b0;
         cnt_ff      <= 0;
         o_trap_done <= 1'b0;
      end else begin
         o_trap_done <= 1'b0;
         if (i_trap_take) begin
            busy_ff <= 1'b1;
            cnt_ff  <= i_slow ? 20 : 1;
         end else if (busy_ff && cnt_ff == 0) begin
            o_trap_done <= 1'b1;
            busy_ff     <= 1'b0;
         end else if (busy_ff) begin
            cnt_ff <= cnt_ff - 1;
         end
      end
   end
endmodule // sxirq_cpu_model
`default_nettype wire

// ### verification/sxirq_bench.sv
// Self-checking bench for the shared interrupt and trap vectoring block.
// Assumes the core model answers every exception taken with a done pulse.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin checks_done++; if ((g) !== (e)) begin err_total++; \
   $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e); end end
module sxirq_bench;
   logic        clk = 1'b0, reset_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0, sw = 1'b0, slow = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [15:0] wdata = 16'h0000, rdata;
   logic [13:0] evt = 14'h0000;
   logic [10:0] cause = 11'h000;
   logic [6:0]  swnum = 7'h00, tnum;
   logic [3:0]  svec, ilvl;
   logic [8:0]  vloc;
   logic [1:0]  tprio;
   logic        done, take, force_lvl, blk;
   int          err_total = 0, checks_done = 0, takes = 0, n;
   logic [3:0]  ev;
   // Per source {vec3, vec2, vec1, vec0} flag bytes
   logic [31:0] map [14] = '{32'h01000001, 32'h02000100, 32'h00020202, 32'h00040404,
      32'h04000000, 32'h00080808, 32'h00101010, 32'h08000000, 32'h00202020, 32'h00404040,
      32'h00808080, 32'h10000000, 32'h20000000, 32'h40010000};
   int          fpos [11] = '{0, 0, 15, 14, 13, 7, 6, 3, 2, 1, 0};

   sxirq_top sxirq_top_inst (.i_core_clk(clk), .i_reset_n(reset_n), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_first_can_unit_evt(evt[0]),
      .i_second_can_unit_evt(evt[1]), .i_i2c_rx_evt(evt[2]), .i_i2c_tx_evt(evt[3]),
      .i_i2c_err_evt(evt[4]), .i_sync_rx_evt(evt[5]), .i_sync_tx_evt(evt[6]),
      .i_sync_err_evt(evt[7]), .i_async_rx_evt(evt[8]), .i_async_tx_evt(evt[9]),
      .i_async_txb_evt(evt[10]), .i_async_err_evt(evt[11]), .i_pll_owd_evt(evt[12]),
      .i_pwm_evt(evt[13]), .i_soft_reset(cause[10]), .i_wdt_reset(cause[9]),
      .i_nmi(cause[8]), .i_stack_over(cause[7]), .i_stack_under(cause[6]),
      .i_class_b(cause[5:0]), .i_sw_trap(sw), .i_sw_trap_num(swnum), .i_trap_done(done),
      .o_shared_vector(svec), .o_trap_take(take), .o_trap_num(tnum), .o_vector_loc(vloc),
      .o_trap_prio(tprio), .o_force_ilvl(force_lvl), .o_cpu_interrupt_level(ilvl),
      .o_irq_block(blk));
   sxirq_cpu_model sxirq_cpu_model_inst (.i_core_clk(clk), .i_reset_n(reset_n),
      .i_trap_take(take), .i_slow(slow), .o_trap_done(done));

   always #10 clk = ~clk;
   always @(posedge clk) if (take === 1'b1) takes++;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk);
      wr_s <= 1'b1; addr <= a; wdata <= v;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [15:0] e, input string m);
      @(posedge clk);
      rd_s <= 1'b1; addr <= a;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      `CHK(rdata, e, m)
   endtask
   task automatic pulse(input int s);
      @(posedge clk);
      evt <= 14'h0001 << s;
      @(posedge clk);
      evt <= 14'h0000;
   endtask
   task automatic fire(input logic [10:0] c, input logic s, input logic [6:0] num);
      @(posedge clk);
      cause <= c; sw <= s; swnum <= num;
      @(posedge clk);
      cause <= 11'h000; sw <= 1'b0;
   endtask
   task automatic expect_take(input logic [6:0] num, input logic [1:0] p, input logic hw);
      int k;
      k = 0;
      // Pulse may already stand when the cause was driven one edge ago
      #1;
      while (take !== 1'b1 && k < 60) begin @(posedge clk); #1; k++; end
      if (take !== 1'b1) begin
         err_total++;
         $display("[FAIL] %0t no exception taken", $time);
         tally_and_finish();
      end else begin
         `CHK(tnum, num, "trap number")
         `CHK(vloc, {num, 2'b00}, "vector location")
         `CHK(tprio, p, "priority")
         `CHK(force_lvl, hw, "level force")
         if (hw) begin `CHK(ilvl, 4'hF, "cpu level") `CHK(blk, 1'b1, "irq block") end
         // Let the pulse end so the next call sees only a fresh one
         @(posedge clk);
         #1;
      end
   endtask
   task automatic wait_idle;
      int k;
      k = 0;
      while (blk !== 1'b0 && k < 100) begin @(posedge clk); #1; k++; end
      `CHK(blk, 1'b0, "service end")
      if (blk !== 1'b0) tally_and_finish();
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      expect_take(7'h00, 2'h3, 1'b1);
      wait_idle();
      for (int a = 0; a < 5; a++) rd_chk(4'(a), 16'h0000, "reset value");
      wr(4'h0, 16'hA5C3);
      rd_chk(4'h0, 16'hA5C3, "select readback");
      wr(4'hF, 16'hFFFF);
      rd_chk(4'hF, 16'h0000, "unmapped read");
      rd_chk(4'h1, 16'h0000, "unmapped write alias");
      $display("test registers done");
      for (int s = 0; s < 14; s++) begin
         for (int m = 0; m < 2; m++) begin
            for (int v = 0; v < 4; v++) wr(4'(v), m ? 16'hFF00 : 16'h0000);
            pulse(s);
            repeat (2) @(posedge clk);
            #1;
            for (int v = 0; v < 4; v++) ev[v] = m && (map[s][8*v+:8] != 8'h00);
            `CHK(svec, ev, "shared vector")
            for (int v = 0; v < 4; v++)
               rd_chk(4'(v), {m ? 8'hFF : 8'h00, map[s][8*v+:8]}, "flag byte");
         end
      end
      $display("test shared vectors done");
      for (int i = 0; i < 11; i++) begin
         wr(4'h4, 16'h0000);
         fire(11'h400 >> i, 1'b0, 7'h00);
         expect_take(i < 2 ? 7'h00 : i < 5 ? 7'(2 * i - 2) : 7'h0A,
                     i < 2 ? 2'h3 : i < 5 ? 2'h2 : 2'h1, 1'b1);
         wait_idle();
         rd_chk(4'h4, i < 2 ? 16'h0000 : 16'h0001 << fpos[i], "trap flag");
      end
      $display("test trap classes done");
      // Lower classes must wait behind higher ones
      fire(11'h101, 1'b0, 7'h00);
      expect_take(7'h02, 2'h2, 1'b1);
      expect_take(7'h0A, 2'h1, 1'b1);
      fire(11'h501, 1'b0, 7'h00);
      expect_take(7'h00, 2'h3, 1'b1);
      expect_take(7'h02, 2'h2, 1'b1);
      expect_take(7'h0A, 2'h1, 1'b1);
      wait_idle();
      fire(11'h000, 1'b1, 7'h7F);
      expect_take(7'h7F, 2'h0, 1'b0);
      wait_idle();
      $display("test priority done");
      for (int v = 0; v < 4; v++) wr(4'(v), v == 0 ? 16'h0100 : 16'h0000);
      pulse(0);
      repeat (2) @(posedge clk);
      #1;
      `CHK(svec, 4'h1, "pending request")
      slow <= 1'b1;
      fire(11'h100, 1'b0, 7'h00);
      expect_take(7'h02, 2'h2, 1'b1);
      n = takes;
      repeat (2) @(posedge clk);
      #1;
      `CHK(svec, 4'h0, "request held off")
      rd_chk(4'h5, {11'h000, 2'h2, 3'b010}, "status in service");
      fire(11'h000, 1'b1, 7'h11);
      wait_idle();
      repeat (5) @(posedge clk);
      #1;
      `CHK(takes, n, "trap refused in service")
      `CHK(svec, 4'h1, "request resumes")
      $display("test service blocking done");
      tally_and_finish();
   end
endmodule // sxirq_bench
`undef CHK
`default_nettype wire
